// >>> hw/art_cfg.svh
// Holds the register offsets, reset values, limits and clock division counts of the timer.
// Assumes it is included by bare name from the package and the design.
`ifndef ART_CFG_SVH
`define ART_CFG_SVH

// ****************************************
// Register offsets
// ****************************************
`define ART_OFS_CONTROL 8'hC8
`define ART_OFS_RELOAD_LOW 8'hCA
`define ART_OFS_RELOAD_HIGH 8'hCB
`define ART_OFS_COUNT_LOW 8'hCC
`define ART_OFS_COUNT_HIGH 8'hCD

// ****************************************
// Reset values and limits
// ****************************************
`define ART_CONTROL_RESET 8'h00
`define ART_BYTE_MAX 8'hFF
`define ART_BYTE_ZERO 8'h00

// ****************************************
// Clock division
// ****************************************
`define ART_SYS_DIV 12
`define ART_DIV12_LAST 4'hB
`define ART_OSC_DIV 8
`define ART_DIV8_LAST 3'h7

`endif

// >>> hw/art_pkg.sv
// Holds the types shared by the timer design.
// Assumes the configuration header is on the include path.
`include "art_cfg.svh"

package art_pkg;

	// ****************************************
	// Control register layout, bit 7 first
	// ****************************************
	typedef struct packed {
		logic high_overflow_flag;
		logic low_overflow_flag;
		logic low_byte_irq_enable;
		logic capture_enable;
		logic split_mode_select;
		logic run_control;
		logic capture_source_select;
		logic external_clock_select;
	} art_ctrl_type;

	// ****************************************
	// Register port request
	// ****************************************
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} art_sfr_req_type;

endpackage : art_pkg

// >>> hw/art_timer.sv
// Holds the 16-bit / split 8-bit auto-reload timer with capture.
// Assumes a single 100 MHz ref_clk, clock-select bits and the timer
// interrupt enable supplied from outside, oscillators arriving as pins.
`timescale 1ns/1ns
`default_nettype none
`include "art_cfg.svh"

module art_timer (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Register port
	input wire art_pkg::art_sfr_req_type sfr_req,
	output logic [7:0] sfr_rdata_q,
	// Clock selects and interrupt enable from outside
	input wire logic high_half_clock_select,
	input wire logic low_half_clock_select,
	input wire logic timer_irq_enable,
	// Oscillator pins: bit 0 external, bit 1 real-time clock
	input wire logic [1:0] osc_pin,
	// Interrupt request
	output logic irq_q
);
	import art_pkg::*;

	art_ctrl_type ctrl_q;
	logic [7:0] count_low_byte_q;
	logic [7:0] count_high_byte_q;
	logic [7:0] reload_low_byte_q;
	logic [7:0] reload_high_byte_q;
	logic [3:0] div12_q;
	wire [1:0] tick8;

	// ****************************************
	// Oscillator synchronisers and divide by 8
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_osc
			logic s1_q;
			logic s2_q;
			logic s3_q;
			logic lvl_q;
			logic tick_q;
			logic [2:0] cnt_q;
			wire agree = (s2_q == s3_q);
			wire rise = agree && s3_q && !lvl_q;
			always_ff @(posedge ref_clk or posedge reset) begin
				if (reset) begin
					s1_q <= 1'b0;
					s2_q <= 1'b0;
					s3_q <= 1'b0;
					lvl_q <= 1'b0;
					cnt_q <= 3'h0;
					tick_q <= 1'b0;
				end else begin
					s1_q <= osc_pin[g];
					s2_q <= s1_q;
					s3_q <= s2_q;
					if (agree)
						lvl_q <= s3_q;
					if (rise)
						cnt_q <= cnt_q + 3'h1;
					tick_q <= rise && (cnt_q == `ART_DIV8_LAST);
				end
			end
			assign tick8[g] = tick_q;
		end
	endgenerate

	// ****************************************
	// System clock divide by 12
	// ****************************************
	wire tick12 = (div12_q == `ART_DIV12_LAST);

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset)
			div12_q <= 4'h0;
		else
			div12_q <= tick12 ? 4'h0 : div12_q + 4'h1;
	end

	// ****************************************
	// Clock selection and counting conditions
	// ****************************************
	wire ext8 = tick8[0];
	wire rtc8 = tick8[1];
	wire split = ctrl_q.split_mode_select;
	wire cen = ctrl_q.capture_enable;
	wire run = ctrl_q.run_control;
	wire xclk = ctrl_q.external_clock_select;
	wire rclk = ctrl_q.capture_source_select;
	wire rtc_count = cen && rclk;
	wire slow_lo = xclk ? (rtc_count ? rtc8 : ext8) : tick12;
	wire slow_hi = xclk ? ext8 : tick12;
	wire tick_lo = low_half_clock_select ? 1'b1 : slow_lo;
	wire tick_hi = high_half_clock_select ? 1'b1 : slow_hi;
	wire cap_evt = cen && (rclk ? ext8 : rtc8);
	wire inc16 = !split && run && tick_lo;
	wire lo_inc = split ? tick_lo : inc16;
	wire lo_max = (count_low_byte_q == `ART_BYTE_MAX);
	wire hi_max = (count_high_byte_q == `ART_BYTE_MAX);
	wire lo_wrap = lo_inc && lo_max;
	wire hi_inc = split ? (run && tick_hi) : (inc16 && lo_max);
	wire hi_wrap = hi_inc && hi_max;
	wire reload_on = split || !cen;
	wire lo_reload = split || (hi_wrap && !cen);

	// ****************************************
	// Register port decode
	// ****************************************
	wire wr_ctrl = sfr_req.wr && (sfr_req.addr == `ART_OFS_CONTROL);
	wire wr_rl_lo = sfr_req.wr && (sfr_req.addr == `ART_OFS_RELOAD_LOW);
	wire wr_rl_hi = sfr_req.wr && (sfr_req.addr == `ART_OFS_RELOAD_HIGH);
	wire wr_cnt_lo = sfr_req.wr && (sfr_req.addr == `ART_OFS_COUNT_LOW);
	wire wr_cnt_hi = sfr_req.wr && (sfr_req.addr == `ART_OFS_COUNT_HIGH);

	// ****************************************
	// Next counter and reload values
	// ****************************************
	wire [7:0] lo_wrap_val = lo_reload ? reload_low_byte_q : `ART_BYTE_ZERO;
	wire [7:0] hi_wrap_val = reload_on ? reload_high_byte_q : `ART_BYTE_ZERO;
	wire [7:0] count_low_byte_d = wr_cnt_lo ? sfr_req.wdata :
		lo_wrap ? lo_wrap_val :
		lo_inc ? count_low_byte_q + 8'h01 : count_low_byte_q;
	wire [7:0] count_high_byte_d = wr_cnt_hi ? sfr_req.wdata :
		hi_wrap ? hi_wrap_val :
		hi_inc ? count_high_byte_q + 8'h01 : count_high_byte_q;
	wire [7:0] reload_low_byte_d = cap_evt ? count_low_byte_q :
		wr_rl_lo ? sfr_req.wdata : reload_low_byte_q;
	wire [7:0] reload_high_byte_d = cap_evt ? count_high_byte_q :
		wr_rl_hi ? sfr_req.wdata : reload_high_byte_q;

	// ****************************************
	// Control register and flags
	// ****************************************
	wire set_hi = cap_evt || (hi_wrap && reload_on);
	wire set_lo = lo_wrap;
	art_ctrl_type ctrl_w;
	art_ctrl_type ctrl_d;
	assign ctrl_w = wr_ctrl ? art_ctrl_type'(sfr_req.wdata) : ctrl_q;

	always_comb begin
		ctrl_d = ctrl_w;
		ctrl_d.high_overflow_flag = ctrl_w.high_overflow_flag | set_hi;
		ctrl_d.low_overflow_flag = ctrl_w.low_overflow_flag | set_lo;
	end

	wire irq_d = timer_irq_enable && (ctrl_q.high_overflow_flag ||
		(ctrl_q.low_byte_irq_enable && ctrl_q.low_overflow_flag));

	// ****************************************
	// Read data selection
	// ****************************************
	logic [7:0] rd_mux;

	always_comb begin
		case (sfr_req.addr)
			`ART_OFS_CONTROL: rd_mux = ctrl_q;
			`ART_OFS_RELOAD_LOW: rd_mux = reload_low_byte_q;
			`ART_OFS_RELOAD_HIGH: rd_mux = reload_high_byte_q;
			`ART_OFS_COUNT_LOW: rd_mux = count_low_byte_q;
			`ART_OFS_COUNT_HIGH: rd_mux = count_high_byte_q;
			default: rd_mux = 8'h00;
		endcase
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			ctrl_q <= `ART_CONTROL_RESET;
			count_low_byte_q <= 8'h00;
			count_high_byte_q <= 8'h00;
			reload_low_byte_q <= 8'h00;
			reload_high_byte_q <= 8'h00;
			irq_q <= 1'b0;
			sfr_rdata_q <= 8'h00;
		end else begin
			ctrl_q <= ctrl_d;
			count_low_byte_q <= count_low_byte_d;
			count_high_byte_q <= count_high_byte_d;
			reload_low_byte_q <= reload_low_byte_d;
			reload_high_byte_q <= reload_high_byte_d;
			irq_q <= irq_d;
			if (sfr_req.rd)
				sfr_rdata_q <= rd_mux;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	a_wrap_reload16: assert property (
		(!split && !cen && hi_wrap && !wr_cnt_lo && !wr_cnt_hi) |=>
		{count_high_byte_q, count_low_byte_q} ==
		$past({reload_high_byte_q, reload_low_byte_q}))
		else $error("16-bit wrap did not reload");
	a_wrap_sets_high: assert property (
		(hi_wrap && reload_on) |=> ctrl_q.high_overflow_flag)
		else $error("high wrap did not set flag");
	a_irq_on_high: assert property (
		(timer_irq_enable && ctrl_q.high_overflow_flag) |=> irq_q)
		else $error("no interrupt on high flag");
	a_irq_low_gated: assert property (
		(timer_irq_enable && ctrl_q.low_overflow_flag &&
		!ctrl_q.low_byte_irq_enable && !ctrl_q.high_overflow_flag) |=> !irq_q)
		else $error("low flag raised interrupt without enable");
	a_split_low_reload: assert property (
		(split && lo_wrap && !wr_cnt_lo) |=>
		count_low_byte_q == $past(reload_low_byte_q))
		else $error("split low did not reload");
	a_split_high_held: assert property (
		(split && !run && !wr_cnt_hi && !wr_ctrl) |=>
		$stable(count_high_byte_q))
		else $error("high half moved while stopped");
	a_split_low_runs: assert property (
		(split && low_half_clock_select && !wr_cnt_lo) |=>
		count_low_byte_q != $past(count_low_byte_q))
		else $error("low half stalled in split mode");
	a_flag_sticky: assert property (
		(ctrl_q.low_overflow_flag && !wr_ctrl) |=> ctrl_q.low_overflow_flag)
		else $error("low flag cleared by hardware");
	a_sys12_rate: assert property (
		tick12 |=> !tick12 [*8] ##1 !tick12 ##1 !tick12 ##1 !tick12
		##1 tick12)
		else $error("divide by 12 wrong period");
	a_capture_copy: assert property (
		cap_evt |=> reload_low_byte_q == $past(count_low_byte_q) &&
		reload_high_byte_q == $past(count_high_byte_q) &&
		ctrl_q.high_overflow_flag)
		else $error("capture did not copy counter");

	// ****************************************
	// Assertions on flags, interrupts, counters and ticks
	// ****************************************
	a_split_high_flag: assert property (
		(split && hi_wrap) |=> ctrl_q.high_overflow_flag)
		else $error("split high wrap did not set flag");
	a_low_flag_sets: assert property (
		lo_wrap |=> ctrl_q.low_overflow_flag)
		else $error("low wrap did not set flag");
	a_high_flag_sticky: assert property (
		(ctrl_q.high_overflow_flag && !wr_ctrl) |=>
		ctrl_q.high_overflow_flag)
		else $error("high flag cleared by hardware");
	a_irq_low_enabled: assert property (
		(timer_irq_enable && ctrl_q.low_byte_irq_enable &&
		ctrl_q.low_overflow_flag) |=> irq_q)
		else $error("no interrupt on enabled low flag");
	a_irq_needs_enable: assert property (
		!timer_irq_enable |=> !irq_q)
		else $error("interrupt without timer enable");
	a_capture_no_reload: assert property (
		(!split && cen && hi_wrap && !wr_cnt_lo && !wr_cnt_hi) |=>
		{count_high_byte_q, count_low_byte_q} == 16'h0000)
		else $error("capture mode wrap reloaded");
	a_split_high_reload: assert property (
		(split && hi_wrap && !wr_cnt_hi) |=>
		count_high_byte_q == $past(reload_high_byte_q))
		else $error("split high did not reload");
	a_stopped_16_held: assert property (
		(!split && !run && !wr_cnt_lo && !wr_cnt_hi) |=>
		$stable({count_high_byte_q, count_low_byte_q}))
		else $error("16-bit counter moved while stopped");
	a_sys_tick_count: assert property (
		(!split && run && low_half_clock_select &&
		!lo_max && !wr_cnt_lo) |=>
		count_low_byte_q == $past(count_low_byte_q) + 8'h01)
		else $error("low byte missed a system clock count");
	a_ext_tick_pulse: assert property (
		ext8 |=> !ext8)
		else $error("external tick longer than one cycle");
	a_rtc_tick_pulse: assert property (
		rtc8 |=> !rtc8)
		else $error("rtc tick longer than one cycle");

	c_rtc_count: cover property (rtc_count && rtc8 && inc16);
	c_split_low_wrap: cover property (split && lo_wrap);
	c_full_wrap16: cover property (!split && hi_wrap);
	c_capture: cover property (cap_evt);
	c_irq_raise: cover property (!irq_q ##1 irq_q);

endmodule : art_timer
`default_nettype wire

// >>> tb/art_timer_tb.sv
// Self-checking testbench for the auto-reload timer with capture.
// Assumes art_pkg and art_timer are compiled first; no partner model.
`timescale 1ns/1ns
`default_nettype none

module art_timer_tb;
	import art_pkg::*;

	logic ref_clk;
	logic reset;
	logic hsel;
	logic lsel;
	logic ien;
	logic [1:0] osc;
	art_sfr_req_type req;
	logic [7:0] rdata;
	logic irq;
	logic [7:0] v;
	int err_count;
	int samples_checked;

	art_timer DUT (
		.ref_clk(ref_clk),
		.reset(reset),
		.sfr_req(req),
		.sfr_rdata_q(rdata),
		.high_half_clock_select(hsel),
		.low_half_clock_select(lsel),
		.timer_irq_enable(ien),
		.osc_pin(osc),
		.irq_q(irq)
	);

	// ****************************************
	// Clock, bus and compare tasks
	// ****************************************
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : cyc

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		req.addr <= a;
		req.wdata <= d;
		req.wr <= 1'b1;
		@(posedge ref_clk);
		req.wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge ref_clk);
		req.rd <= 1'b0;
		#1;
		v = rdata;
	endtask : rd

	task automatic check_eq(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask : check_eq

	task automatic check_rng(input logic [7:0] got, lo, hi);
		samples_checked++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			err_count++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, lo);
		end
	endtask : check_rng

	// Oscillator pin, 4 cycles high and 4 low per period
	task automatic osc_run(input int idx, input int n);
		repeat (n) begin
			osc <= (idx == 0) ? 2'b01 : 2'b10;
			cyc(4);
			osc <= 2'b00;
			cyc(4);
		end
	endtask : osc_run

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		rd(8'hC8); check_eq(v, 8'h00);
		rd(8'hCA); check_eq(v, 8'h00);
		wr(8'h10, 8'hFF);
		rd(8'h10); check_eq(v, 8'h00);
		rd(8'hCC); check_eq(v, 8'h00);
	endtask : t_reset

	task automatic t_wide();
		wr(8'hCA, 8'h34);
		wr(8'hCB, 8'h12);
		wr(8'hCC, 8'hFA);
		wr(8'hCD, 8'hFF);
		wr(8'hC8, 8'h04);
		cyc(12);
		check_eq(irq, 1'b1);
		wr(8'hC8, 8'h80);
		rd(8'hC8); check_eq(v, 8'h80);
		rd(8'hCD); check_eq(v, 8'h12);
		rd(8'hCC); check_rng(v, 8'h34, 8'h4F);
		cyc(20);
		rd(8'hC8); check_eq(v, 8'h80);
		cyc(1);
		ien <= 1'b0;
		cyc(2);
		check_eq(irq, 1'b0);
		ien <= 1'b1;
		cyc(2);
		check_eq(irq, 1'b1);
		wr(8'hC8, 8'h00);
		cyc(2);
		check_eq(irq, 1'b0);
	endtask : t_wide

	task automatic t_low_irq();
		wr(8'hCC, 8'hFD);
		wr(8'hCD, 8'h00);
		wr(8'hC8, 8'h04);
		cyc(8);
		check_eq(irq, 1'b0);
		rd(8'hC8); check_eq(v, 8'h44);
		wr(8'hC8, 8'h20);
		wr(8'hCC, 8'hFD);
		wr(8'hC8, 8'h24);
		cyc(8);
		check_eq(irq, 1'b1);
		wr(8'hC8, 8'h00);
	endtask : t_low_irq

	task automatic t_split();
		wr(8'hCA, 8'hF0);
		wr(8'hCB, 8'hA0);
		wr(8'hCC, 8'hFC);
		wr(8'hCD, 8'hFE);
		wr(8'hC8, 8'h08);
		cyc(10);
		rd(8'hCC); check_rng(v, 8'hF0, 8'hFF);
		rd(8'hC8); check_eq(v, 8'h48);
		rd(8'hCD); check_eq(v, 8'hFE);
		check_eq(irq, 1'b0);
		wr(8'hC8, 8'h0C);
		cyc(4);
		check_eq(irq, 1'b1);
		rd(8'hCD); check_rng(v, 8'hA0, 8'hAF);
		wr(8'hC8, 8'h00);
	endtask : t_split

	task automatic t_clocks();
		lsel <= 1'b0;
		wr(8'hCC, 8'h00);
		wr(8'hCD, 8'h00);
		wr(8'hC8, 8'h04);
		cyc(120);
		wr(8'hC8, 8'h00);
		rd(8'hCC); check_rng(v, 8'h09, 8'h0C);
		wr(8'hCD, 8'h00);
		hsel <= 1'b0;
		wr(8'hC8, 8'h0C);
		cyc(120);
		wr(8'hC8, 8'h08);
		rd(8'hCD); check_rng(v, 8'h09, 8'h0C);
		wr(8'hC8, 8'h00);
		hsel <= 1'b1;
		wr(8'hCC, 8'h00);
		wr(8'hC8, 8'h05);
		osc_run(0, 24);
		cyc(8);
		wr(8'hC8, 8'h00);
		rd(8'hCC); check_eq(v, 8'h03);
		lsel <= 1'b1;
	endtask : t_clocks

	task automatic t_capture();
		wr(8'hCC, 8'h00);
		wr(8'hCD, 8'h00);
		wr(8'hC8, 8'h14);
		osc_run(1, 8);
		cyc(8);
		rd(8'hC8); check_eq(v, 8'h94);
		rd(8'hCB); check_eq(v, 8'h00);
		rd(8'hCA); check_rng(v, 8'h38, 8'h50);
		wr(8'hC8, 8'h16);
		osc_run(0, 8);
		cyc(8);
		rd(8'hC8); check_eq(v, 8'h96);
		wr(8'hC8, 8'h00);
		lsel <= 1'b0;
		wr(8'hCC, 8'h00);
		wr(8'hCD, 8'h00);
		wr(8'hC8, 8'h17);
		osc_run(1, 16);
		cyc(8);
		rd(8'hC8); check_eq(v, 8'h17);
		wr(8'hC8, 8'h00);
		rd(8'hCC); check_eq(v, 8'h02);
		lsel <= 1'b1;
	endtask : t_capture

	// ****************************************
	// Sequence, watchdog and verdict
	// ****************************************
	task automatic close_out();
		$display("errors %0d checks %0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : close_out

	initial begin
		err_count = 0;
		samples_checked = 0;
		reset = 1'b1;
		req = '0;
		hsel = 1'b1;
		lsel = 1'b1;
		ien = 1'b1;
		osc = 2'b00;
		cyc(12);
		reset <= 1'b0;
		t_reset();
		t_wide();
		t_low_irq();
		t_split();
		t_clocks();
		t_capture();
		close_out();
	end

	initial begin
		#300000;
		err_count++;
		close_out();
	end

endmodule : art_timer_tb

`default_nettype wire
